// ### pts_pkg.sv
// Purpose: shared constants and types of the programmable threshold stage
// Assumes: 32-bit APB register words, 200 MHz core clock
// Notes: all offsets are byte addresses
package pts_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned EVAL_PERIOD_US = 5000;
	localparam int unsigned EVAL_TICK_CYC = EVAL_PERIOD_US * CLK_MHZ;
	localparam int unsigned STAGE_MAX = 10;
	localparam int unsigned MEAS_W = 16;
	localparam int unsigned MEAS_PER_CAT = 8;
	localparam int unsigned MEAS_TOTAL = 40;
	localparam logic [2:0] CAT_LAST = 3'h4;

	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CONFIG = 12'h004;
	localparam logic [11:0] ADDR_SELECT = 12'h008;
	localparam logic [11:0] ADDR_MULT0 = 12'h00C;
	localparam logic [11:0] ADDR_MULT1 = 12'h010;
	localparam logic [11:0] ADDR_MULT2 = 12'h014;
	localparam logic [11:0] ADDR_STATUS = 12'h018;
	localparam logic [11:0] ADDR_TIMER = 12'h01C;
	// group pages at 0x020 and 0x030: thr0, thr1, thr2, delay
	localparam logic [6:0] GROUP_PAGE = 7'h01;
	localparam logic [1:0] GROUP_DELAY_WORD = 2'h3;

	localparam logic [1:0] COUNT_ONE = 2'h0;
	localparam logic [1:0] COUNT_TWO = 2'h1;
	localparam logic [1:0] COUNT_THREE = 2'h2;

	localparam logic [2:0] H2_PROD = 3'h0;
	localparam logic [2:0] H2_QUOT = 3'h1;
	localparam logic [2:0] H2_MAX = 3'h2;
	localparam logic [2:0] H2_MIN = 3'h3;
	localparam logic [2:0] H2_OR = 3'h4;
	localparam logic [2:0] H2_AND = 3'h5;
	localparam logic [2:0] H2_DIFF = 3'h6;
	localparam logic [2:0] H3_PROD = 3'h0;
	localparam logic [2:0] H3_MAX = 3'h1;
	localparam logic [2:0] H3_MIN = 3'h2;
	localparam logic [2:0] H3_OR = 3'h3;
	localparam logic [2:0] H3_AND = 3'h4;
	localparam logic [2:0] H3_ORAND = 3'h5;

	typedef enum logic [2:0] {
		MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLOCKED, MODE_OFF
	} pts_mode_type;

	typedef enum logic [2:0] {
		COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED, COND_DISABLED
	} pts_cond_type;

	typedef enum logic [1:0] {
		FORCE_NORMAL, FORCE_START, FORCE_TRIP, FORCE_BLOCKED
	} pts_force_type;

	typedef struct packed {
		logic [23:0] rsv;
		logic pickUnder;
		logic [1:0] forceSel;
		logic forceAllow;
		logic enable;
		logic [2:0] mode;
	} pts_ctrl_type;

	typedef struct packed {
		logic [22:0] rsv;
		logic [3:0] availCount;
		logic [2:0] handling;
		logic [1:0] count;
	} pts_config_type;

	typedef struct packed {
		logic [21:0] rsv;
		logic test;
		logic divInvalid;
		logic trip;
		logic start;
		logic [2:0] cond;
		logic [2:0] behaviour;
	} pts_status_type;

	localparam pts_ctrl_type CTRL_RESET = 32'h0000_0004;
	localparam pts_config_type CONFIG_RESET = 32'h0000_0020;
	localparam logic [23:0] MULT_RESET = 24'h00_0001;
	localparam logic [31:0] THR_RESET = 32'h0000_0000;
	localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
endpackage : pts_pkg

// ### pts_combiner.sv
// Purpose: combines up to three scaled values into one pick-up decision
// Assumes: values already scaled, thresholds from the active group
// Notes: purely combinational; the caller samples it on the cycle tick
`timescale 1ns/10ps
`default_nettype none
module pts_combiner (
	input wire logic signed [39:0] valA, // first scaled value
	input wire logic signed [39:0] valB, // second scaled value
	input wire logic signed [39:0] valC, // third scaled value
	input wire logic signed [31:0] thrA, // threshold of first
	input wire logic signed [31:0] thrB, // threshold of second
	input wire logic signed [31:0] thrC, // threshold of third
	input wire logic [1:0] count, // number of inputs used
	input wire logic [2:0] handling, // combination selector
	input wire logic pickUnder, // under instead of over
	output logic pickup, // condition met
	output logic divInvalid // quotient with zero divisor
);
	function automatic logic meets(input logic signed [119:0] v,
		input logic signed [31:0] t, input logic under);
		logic signed [119:0] te;
		te = 120'(t);
		return under ? (v < te) : (v > te);
	endfunction : meets

	always_comb begin
		logic signed [119:0] a;
		logic signed [119:0] b;
		logic signed [119:0] c;
		logic signed [119:0] mx2;
		logic signed [119:0] mn2;
		logic ma;
		logic mb;
		logic mc;
		a = 120'(valA);
		b = 120'(valB);
		c = 120'(valC);
		mx2 = (a > b) ? a : b;
		mn2 = (a < b) ? a : b;
		ma = meets(a, thrA, pickUnder);
		mb = meets(b, thrB, pickUnder);
		mc = meets(c, thrC, pickUnder);
		pickup = 1'b0;
		divInvalid = 1'b0;
		case (count)
			pts_pkg::COUNT_ONE: pickup = ma;
			pts_pkg::COUNT_TWO: begin
				case (handling)
					pts_pkg::H2_PROD: pickup = meets(a * b, thrA, pickUnder);
					pts_pkg::H2_QUOT: begin
						// zero divisor: no pick-up, flagged instead
						if (b == '0) divInvalid = 1'b1;
						else pickup = meets(a / b, thrA, pickUnder);
					end
					pts_pkg::H2_MAX: pickup = meets(mx2, thrA, pickUnder);
					pts_pkg::H2_MIN: pickup = meets(mn2, thrA, pickUnder);
					pts_pkg::H2_OR: pickup = ma | mb;
					pts_pkg::H2_AND: pickup = ma & mb;
					pts_pkg::H2_DIFF: pickup = meets(a - b, thrA, pickUnder);
					default: pickup = 1'b0;
				endcase
			end
			pts_pkg::COUNT_THREE: begin
				case (handling)
					pts_pkg::H3_PROD: pickup = meets(a * b * c, thrA, pickUnder);
					pts_pkg::H3_MAX: pickup = meets((mx2 > c) ? mx2 : c, thrA,
						pickUnder);
					pts_pkg::H3_MIN: pickup = meets((mn2 < c) ? mn2 : c, thrA,
						pickUnder);
					pts_pkg::H3_OR: pickup = ma | mb | mc;
					pts_pkg::H3_AND: pickup = ma & mb & mc;
					pts_pkg::H3_ORAND: pickup = (ma | mb) & mc;
					default: pickup = 1'b0;
				endcase
			end
			default: pickup = 1'b0;
		endcase
	end
endmodule : pts_combiner
`default_nettype wire

// ### pts_stage.sv
// Purpose: one programmable threshold stage with APB registers
// Assumes: measurements synchronous to core_clk, APB4 master
// Notes: evaluates once per cycle tick; outputs registered
//
// Notes on behaviour
// - operating mode on, blocked, test, test/blocked or off steers the stage
// - effective behaviour readable, same five-value encoding as the mode
// - general configuration does not follow the setting group switch
// - when forcing allowed, status forced to normal, start, trip or blocked
// - one, two or three measurement magnitudes feed the pick-up
// - two inputs, product: first times second against threshold
// - two inputs, quotient: first divided by second against threshold
// - two inputs, maximum: larger value against threshold
// - two inputs, minimum: smaller value against threshold
// - two inputs, OR: own thresholds, either meeting picks up
// - two inputs, AND: own thresholds, both must meet
// - two inputs, difference: first minus second against threshold
// - three inputs, product of all three against threshold
// - three inputs, maximum: largest value against threshold
// - three inputs, minimum: smallest value against threshold
// - three inputs, OR: own thresholds, any meeting picks up
// - three inputs, AND: own thresholds, all must meet
// - mixed: third meets plus at least one of first two
// - each input chosen by category first, then measurement within it
// - each measurement scaled by signed multiplier, default one
// - one to ten stages available, count configurable
// - stage evaluates only when enabled, otherwise reports disabled
// - evaluation runs every five milliseconds
// - trip only after pick-up persists through the definite delay
`timescale 1ns/10ps
`default_nettype none
module pts_stage #(
	parameter int unsigned StageIndex = 1,
	parameter int unsigned TickCycles = pts_pkg::EVAL_TICK_CYC
) (
	input wire logic core_clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [pts_pkg::MEAS_TOTAL-1:0][15:0] measIn, // measurements
	input wire logic groupSel, // active setting group
	output logic startOut, // start indication
	output logic tripOut, // trip indication
	output logic testOut, // outputs produced in test mode
	output logic [2:0] behaviourOut // node_effective_behaviour
);
	pts_pkg::pts_ctrl_type ctrlQ;
	pts_pkg::pts_config_type cfgQ;
	logic [17:0] selQ;
	logic [23:0] multQ [3];
	logic [31:0] grpQ [2][4];
	logic preadyQ;
	logic [31:0] prdataQ;
	logic pslverrQ;
	logic [31:0] rdData;
	logic rdErr;
	logic [31:0] wrWord;
	logic access;
	logic [31:0] tickCntQ;
	logic tick;
	logic stageActive;
	logic evalOk;
	logic signed [39:0] scaled [3];
	logic signed [31:0] thrSel [3];
	logic [31:0] delaySel;
	logic pickNow;
	logic divNow;
	logic pickQ;
	logic divQ;
	logic tripStQ;
	logic [31:0] timerQ;
	pts_pkg::pts_cond_type condD;
	pts_pkg::pts_cond_type condQ;
	logic startD;
	logic tripD;
	logic testD;
	logic [2:0] behD;

	// byte-lane merge for APB4 strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) r[8*b +: 8] = wd[8*b +: 8];
		end
		return r;
	endfunction : merge

	// category in the high bits, channel in the low bits
	function automatic logic signed [15:0] pickMeas(input logic [5:0] sel,
		input logic [pts_pkg::MEAS_TOTAL-1:0][15:0] m);
		logic signed [15:0] r;
		r = '0;
		if (sel[5:3] <= pts_pkg::CAT_LAST) r = m[sel];
		return r;
	endfunction : pickMeas

	assign access = psel && penable;
	assign prdata = prdataQ;
	assign pready = preadyQ;
	assign pslverr = pslverrQ;

	always_comb begin
		rdData = '0;
		rdErr = 1'b0;
		case (paddr)
			pts_pkg::ADDR_CTRL: rdData = ctrlQ;
			pts_pkg::ADDR_CONFIG: rdData = cfgQ;
			pts_pkg::ADDR_SELECT: rdData = 32'(selQ);
			pts_pkg::ADDR_MULT0: rdData = 32'(signed'(multQ[0]));
			pts_pkg::ADDR_MULT1: rdData = 32'(signed'(multQ[1]));
			pts_pkg::ADDR_MULT2: rdData = 32'(signed'(multQ[2]));
			pts_pkg::ADDR_STATUS: rdData = {22'h00_0000, testOut, divQ,
				tripOut, startOut, condQ, behaviourOut};
			pts_pkg::ADDR_TIMER: rdData = timerQ;
			default: begin
				if (paddr[11:5] == pts_pkg::GROUP_PAGE && paddr[1:0] == 2'h0)
					rdData = grpQ[paddr[4]][paddr[3:2]];
				else
					rdErr = 1'b1;
			end
		endcase
	end

	// one wait state so that read data leaves a flip-flop
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			preadyQ <= 1'b0;
			prdataQ <= '0;
			pslverrQ <= 1'b0;
		end else if (access && !preadyQ) begin
			preadyQ <= 1'b1;
			prdataQ <= pwrite ? 32'h0000_0000 : rdData;
			pslverrQ <= rdErr;
		end else begin
			preadyQ <= 1'b0;
			prdataQ <= '0;
			pslverrQ <= 1'b0;
		end
	end

	// old word taken from the read mux, so unstrobed lanes keep their value
	assign wrWord = merge(rdData, pwdata, pstrb);

	// writes commit at the edge where pready is sampled high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlQ <= pts_pkg::CTRL_RESET;
			cfgQ <= pts_pkg::CONFIG_RESET;
			selQ <= '0;
			for (int i = 0; i < 3; i++) multQ[i] <= pts_pkg::MULT_RESET;
			for (int g = 0; g < 2; g++) begin
				for (int r = 0; r < 3; r++) grpQ[g][r] <= pts_pkg::THR_RESET;
				grpQ[g][pts_pkg::GROUP_DELAY_WORD] <= pts_pkg::DELAY_RESET;
			end
		end else if (access && preadyQ && pwrite && !rdErr) begin
			case (paddr)
				pts_pkg::ADDR_CTRL: begin
					ctrlQ[7:3] <= wrWord[7:3];
					// unknown mode codes are dropped, old mode kept
					if (wrWord[2:0] <= 3'(pts_pkg::MODE_OFF))
						ctrlQ.mode <= wrWord[2:0];
				end
				pts_pkg::ADDR_CONFIG: begin
					if (wrWord[1:0] <= pts_pkg::COUNT_THREE)
						cfgQ.count <= wrWord[1:0];
					cfgQ.handling <= wrWord[4:2];
					if (wrWord[8:5] != 4'h0
						&& wrWord[8:5] <= 4'(pts_pkg::STAGE_MAX))
						cfgQ.availCount <= wrWord[8:5];
				end
				pts_pkg::ADDR_SELECT: selQ <= wrWord[17:0];
				pts_pkg::ADDR_MULT0: multQ[0] <= wrWord[23:0];
				pts_pkg::ADDR_MULT1: multQ[1] <= wrWord[23:0];
				pts_pkg::ADDR_MULT2: multQ[2] <= wrWord[23:0];
				default: begin
					if (paddr[11:5] == pts_pkg::GROUP_PAGE)
						grpQ[paddr[4]][paddr[3:2]] <= wrWord;
				end
			endcase
		end
	end

	// mode, handling and selection live outside the groups
	assign delaySel = grpQ[groupSel][pts_pkg::GROUP_DELAY_WORD];

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_input
			assign scaled[i] = 40'(pickMeas(selQ[6*i +: 6], measIn))
				* 40'(signed'(multQ[i]));
			assign thrSel[i] = signed'(grpQ[groupSel][i]);
		end
	endgenerate

	pts_combiner u_combiner (
		.valA(scaled[0]),
		.valB(scaled[1]),
		.valC(scaled[2]),
		.thrA(thrSel[0]),
		.thrB(thrSel[1]),
		.thrC(thrSel[2]),
		.count(cfgQ.count),
		.handling(cfgQ.handling),
		.pickUnder(ctrlQ.pickUnder),
		.pickup(pickNow),
		.divInvalid(divNow)
	);

	assign tick = (tickCntQ == TickCycles - 1);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) tickCntQ <= '0;
		else if (tick) tickCntQ <= '0;
		else tickCntQ <= tickCntQ + 32'h0000_0001;
	end

	// availability alone does not start the stage
	assign stageActive = ctrlQ.enable
		&& (4'(StageIndex) <= cfgQ.availCount);
	assign evalOk = stageActive && (ctrlQ.mode == 3'(pts_pkg::MODE_ON)
		|| ctrlQ.mode == 3'(pts_pkg::MODE_TEST));

	// trip at the (delay+1)th consecutive pick-up tick
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pickQ <= 1'b0;
			divQ <= 1'b0;
			tripStQ <= 1'b0;
			timerQ <= '0;
		end else if (!evalOk) begin
			pickQ <= 1'b0;
			divQ <= 1'b0;
			tripStQ <= 1'b0;
			timerQ <= '0;
		end else if (tick) begin
			pickQ <= pickNow;
			divQ <= divNow;
			if (!pickNow) begin
				tripStQ <= 1'b0;
				timerQ <= '0;
			end else if (timerQ >= delaySel) begin
				tripStQ <= 1'b1;
			end else begin
				timerQ <= timerQ + 32'h0000_0001;
			end
		end
	end

	always_comb begin
		condD = pts_pkg::COND_NORMAL;
		startD = 1'b0;
		tripD = 1'b0;
		testD = 1'b0;
		behD = stageActive ? ctrlQ.mode : 3'(pts_pkg::MODE_OFF);
		if (!stageActive) begin
			condD = pts_pkg::COND_DISABLED;
		end else if (ctrlQ.forceAllow) begin
			case (pts_pkg::pts_force_type'(ctrlQ.forceSel))
				pts_pkg::FORCE_START: begin
					condD = pts_pkg::COND_START;
					startD = 1'b1;
				end
				pts_pkg::FORCE_TRIP: begin
					condD = pts_pkg::COND_TRIP;
					startD = 1'b1;
					tripD = 1'b1;
				end
				pts_pkg::FORCE_BLOCKED: condD = pts_pkg::COND_BLOCKED;
				default: condD = pts_pkg::COND_NORMAL;
			endcase
		end else begin
			case (pts_pkg::pts_mode_type'(ctrlQ.mode))
				pts_pkg::MODE_ON, pts_pkg::MODE_TEST: begin
					startD = pickQ;
					tripD = tripStQ;
					testD = ctrlQ.mode == 3'(pts_pkg::MODE_TEST);
					if (tripStQ) condD = pts_pkg::COND_TRIP;
					else if (pickQ) condD = pts_pkg::COND_START;
				end
				pts_pkg::MODE_OFF: condD = pts_pkg::COND_DISABLED;
				default: condD = pts_pkg::COND_BLOCKED;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			condQ <= pts_pkg::COND_DISABLED;
			startOut <= 1'b0;
			tripOut <= 1'b0;
			testOut <= 1'b0;
			behaviourOut <= 3'(pts_pkg::MODE_OFF);
		end else begin
			condQ <= condD;
			startOut <= startD;
			tripOut <= tripD;
			testOut <= testD;
			behaviourOut <= behD;
		end
	end

	// helper: free-running model of the tick spacing, never reads tick
	logic [31:0] gapQ;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) gapQ <= '0;
		else if (gapQ == TickCycles - 1) gapQ <= '0;
		else gapQ <= gapQ + 32'h0000_0001;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	quiet_when_idle_a: assert property (
		(!stageActive || (!evalOk && !ctrlQ.forceAllow))
		|=> (!startOut && !tripOut))
		else $error("start or trip while stage idle");
	trip_implies_start_a: assert property (
		tripOut |-> startOut)
		else $error("trip without start");
	trip_delay_hold_a: assert property (
		(evalOk && tick && pickNow && timerQ < delaySel && !tripStQ)
		|=> !tripStQ)
		else $error("trip before delay elapsed");
	div_zero_block_a: assert property (
		(cfgQ.count == pts_pkg::COUNT_TWO && cfgQ.handling == pts_pkg::H2_QUOT
		&& scaled[1] == '0) |-> (!pickNow && divNow))
		else $error("pick-up with zero divisor");
	behaviour_off_a: assert property (
		!stageActive |=> behaviourOut == 3'(pts_pkg::MODE_OFF)
		&& condQ == pts_pkg::COND_DISABLED)
		else $error("inactive stage not reported disabled");
	behaviour_mode_a: assert property (
		stageActive |=> behaviourOut == $past(ctrlQ.mode))
		else $error("behaviour differs from mode");
	tick_period_a: assert property (
		tick == (gapQ == TickCycles - 1))
		else $error("evaluation tick period wrong");
	force_trip_a: assert property (
		(stageActive && ctrlQ.forceAllow
		&& ctrlQ.forceSel == 2'(pts_pkg::FORCE_TRIP))
		|=> (tripOut && startOut && condQ == pts_pkg::COND_TRIP))
		else $error("forced trip not shown");
	max_pick_a: assert property (
		(cfgQ.count == pts_pkg::COUNT_TWO && cfgQ.handling == pts_pkg::H2_MAX
		&& !ctrlQ.pickUnder) |-> pickNow == (scaled[0] > 40'(thrSel[0])
		|| scaled[1] > 40'(thrSel[0])))
		else $error("maximum handling wrong");
	and_pick_a: assert property (
		(cfgQ.count == pts_pkg::COUNT_TWO && cfgQ.handling == pts_pkg::H2_AND
		&& !ctrlQ.pickUnder) |-> pickNow == (scaled[0] > 40'(thrSel[0])
		&& scaled[1] > 40'(thrSel[1])))
		else $error("and handling wrong");

	trip_seen_c: cover property (evalOk && !ctrlQ.forceAllow ##1 tripOut);
	div_invalid_c: cover property (tick && evalOk && divNow);
	test_start_c: cover property (testOut && startOut);
	forced_block_c: cover property (condQ == pts_pkg::COND_BLOCKED
		&& ctrlQ.forceAllow);
endmodule : pts_stage
`default_nettype wire

// ### pts_meas_model.sv
// Purpose: measurement subsystem stand-in that feeds the stage
// Assumes: bench loads one channel per cycle
// Notes: a value holds until reloaded, like a refreshed measurement
`timescale 1ns/10ps
`default_nettype none
module pts_meas_model (
	input wire logic core_clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic setWe, // load strobe
	input wire logic [5:0] setIdx, // category*8 + channel
	input wire logic [15:0] setVal, // signed value
	output logic [pts_pkg::MEAS_TOTAL-1:0][15:0] measIn // to the stage
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			measIn <= '0;
		end else if (setWe) begin
			measIn[setIdx] <= setVal;
		end
	end
endmodule : pts_meas_model
`default_nettype wire

// ### programmable_threshold_stage_tb.sv
// Purpose: self-checking bench of the threshold stage
// Assumes: short tick of 20 cycles, one stage instance
// Notes: reads are checked by a monitor against queued notes
`timescale 1ns/10ps
`default_nettype none
module programmable_threshold_stage_tb;
	localparam int TC = 20;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] m;
		logic e;
	} pts_exp_type;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, startOut, tripOut, testOut;
	logic [2:0] behaviourOut;
	logic groupSel = 1'b0;
	logic setWe = 1'b0;
	logic [5:0] setIdx = 6'h00;
	logic [15:0] setVal = 16'h0000;
	logic [pts_pkg::MEAS_TOTAL-1:0][15:0] measIn;
	pts_exp_type expQ[$];
	pts_exp_type ex;
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 32'hbfdd;

	always #2.5 core_clk = ~core_clk;

	pts_meas_model i_pts_meas_model (.core_clk(core_clk), .rst_n(rst_n),
		.setWe(setWe), .setIdx(setIdx), .setVal(setVal), .measIn(measIn));
	pts_stage #(.TickCycles(TC)) i_pts_stage (.core_clk(core_clk),
		.rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .measIn(measIn),
		.groupSel(groupSel), .startOut(startOut), .tripOut(tripOut),
		.testOut(testOut), .behaviourOut(behaviourOut));

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) check("pready", 32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] m = 32'hFFFF_FFFF, input logic e = 1'b0);
		expQ.push_back('{d, m, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// loads first, second and third inputs: channels 0, 1 and 8
	task setAbc(input int a, input int b, input int c);
		@(posedge core_clk);
		setWe <= 1'b1;
		setIdx <= 6'h00;
		setVal <= a[15:0];
		@(posedge core_clk);
		setIdx <= 6'h01;
		setVal <= b[15:0];
		@(posedge core_clk);
		setIdx <= 6'h08;
		setVal <= c[15:0];
		@(posedge core_clk);
		setWe <= 1'b0;
	endtask : setAbc

	// two ticks or more, so any pick-up change has reached the outputs
	task settle;
		repeat (50) @(posedge core_clk);
	endtask : settle

	function automatic logic pick(int n, int h, int a, int b, int c,
		int t0, int t1, int t2);
		if (n == 0) return a > t0;
		if (n == 1) begin
			case (h)
				0: return a * b > t0;
				1: return b != 0 && a / b > t0;
				2: return (a > b ? a : b) > t0;
				3: return (a < b ? a : b) > t0;
				4: return a > t0 || b > t1;
				5: return a > t0 && b > t1;
				default: return a - b > t0;
			endcase
		end
		case (h)
			0: return a * b * c > t0;
			1: return a > t0 || b > t0 || c > t0;
			2: return a > t0 && b > t0 && c > t0;
			3: return a > t0 || b > t1 || c > t2;
			4: return a > t0 && b > t1 && c > t2;
			default: return (a > t0 || b > t1) && c > t2;
		endcase
	endfunction : pick

	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expQ.size() == 0) begin
				check("unexpected read", 32'h0, 32'h1);
			end else begin
				ex = expQ.pop_front();
				check("prdata", prdata & ex.m, ex.d);
				check("pslverr", {31'h0, pslverr}, {31'h0, ex.e});
			end
		end
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		n_mismatch++;
		end_sim();
	end

	initial begin
		int a, b, c, t0, t1, t2, n;
		logic exp, dz;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(pts_pkg::ADDR_CTRL, 32'h0000_0004);
		rd(pts_pkg::ADDR_CONFIG, 32'h0000_0020);
		rd(pts_pkg::ADDR_MULT0, 32'h0000_0001);
		rd(pts_pkg::ADDR_STATUS, 32'h0000_0024, 32'h0000_03FF);
		rd(12'h040, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
		apb(1'b1, pts_pkg::ADDR_SELECT, 32'h0000_8040);
		apb(1'b1, pts_pkg::ADDR_CTRL, 32'h0000_0008);
		for (int k = 0; k < 3; k++) begin
			for (int h = 0; h <= (k == 0 ? 0 : (k == 1 ? 6 : 5)); h++) begin
				for (int r = 0; r < 2; r++) begin
					a = $random(seed) % 100;
					b = (r == 1) ? 0 : $random(seed) % 100;
					c = $random(seed) % 100;
					t0 = $random(seed) % 2000;
					t1 = $random(seed) % 100;
					t2 = $random(seed) % 100;
					setAbc(a, b, c);
					apb(1'b1, 12'h020, t0);
					apb(1'b1, 12'h024, t1);
					apb(1'b1, 12'h028, t2);
					apb(1'b1, pts_pkg::ADDR_CONFIG, k | (h << 2) | 32'h20);
					settle();
					exp = pick(k, h, a, b, c, t0, t1, t2);
					dz = (k == 1 && h == 1 && b == 0);
					check("startOut", startOut, exp);
					check("tripOut", tripOut, exp);
					rd(pts_pkg::ADDR_STATUS, {exp, 6'h0} | {dz, 8'h0},
						32'h0000_0140);
				end
			end
		end
		apb(1'b1, pts_pkg::ADDR_CONFIG, 32'h0000_0020);
		setAbc(5, 1, 1);
		apb(1'b1, 12'h020, 32'h0000_0000);
		apb(1'b1, pts_pkg::ADDR_MULT0, 32'h00FF_FFFE);
		rd(pts_pkg::ADDR_MULT0, 32'hFFFF_FFFE);
		settle();
		check("startOut neg mult", startOut, 32'h0);
		apb(1'b1, pts_pkg::ADDR_MULT0, 32'h0000_0001);
		for (int m = 0; m < 5; m++) begin
			apb(1'b1, pts_pkg::ADDR_CTRL, m | 32'h8);
			settle();
			check("behaviourOut", behaviourOut, m);
			check("startOut mode", startOut, m == 0 || m == 2);
			check("testOut", testOut, m == 2);
		end
		apb(1'b1, pts_pkg::ADDR_CTRL, 32'h0000_000F);
		rd(pts_pkg::ADDR_CTRL, 32'h0000_000C);
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, pts_pkg::ADDR_CTRL, (f << 5) | 32'h18);
			repeat (5) @(posedge core_clk);
			rd(pts_pkg::ADDR_STATUS, f << 3, 32'h0000_0038);
		end
		apb(1'b1, pts_pkg::ADDR_CTRL, 32'h0000_0008);
		apb(1'b1, 12'h020, 32'h0000_03E8);
		apb(1'b1, 12'h02C, 32'h0000_0003);
		settle();
		apb(1'b1, 12'h020, 32'h0000_0000);
		n = 0;
		while (startOut !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		n = 0;
		while (tripOut !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			n++;
		end
		check("trip delay", n, 3 * TC);
		apb(1'b1, 12'h030, 32'h0000_03E8);
		groupSel <= 1'b1;
		settle();
		check("startOut group1", startOut, 32'h0);
		// count 3 and zero available stages are refused, old fields kept
		apb(1'b1, pts_pkg::ADDR_CONFIG, 32'h0000_0003);
		rd(pts_pkg::ADDR_CONFIG, 32'h0000_0020);
		groupSel <= 1'b0;
		settle();
		check("startOut group0", startOut, 32'h1);
		// under-comparison: 5 is not below 0, but is below 1000
		apb(1'b1, pts_pkg::ADDR_CTRL, 32'h0000_0088);
		settle();
		check("startOut under", startOut, 32'h0);
		apb(1'b1, 12'h020, 32'h0000_03E8);
		settle();
		check("startOut under pick", startOut, 32'h1);
		apb(1'b1, pts_pkg::ADDR_CTRL, 32'h0000_0000);
		settle();
		check("startOut off", startOut, 32'h0);
		check("behaviour off", behaviourOut, 32'h4);
		// mid-run reset: control word must return to its reset value
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(pts_pkg::ADDR_CTRL, 32'h0000_0004);
		check("behaviour reset", behaviourOut, 32'h4);
		end_sim();
	end
endmodule : programmable_threshold_stage_tb
`default_nettype wire
